//--- shared/usbcs_pkg.sv
package usbcs_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_STAT = 8'h00;
  localparam logic [7:0] OFF_CON = 8'h04;
  localparam logic [7:0] OFF_ADDR = 8'h08;
  localparam logic [7:0] OFF_TOK = 8'h0c;
  localparam logic [7:0] OFF_SOF = 8'h10;
  localparam logic [7:0] OFF_CFG1 = 8'h14;
  localparam logic [7:0] OFF_CFG2 = 8'h18;
  // ----------------------------------------
  // control, address and config register bit positions
  // ----------------------------------------
  localparam int CON_JFLAG = 7;
  localparam int CON_SE0 = 6;
  localparam int CON_PKT = 5;
  localparam int CON_RST = 4;
  localparam int CON_HOST = 3;
  localparam int CON_RESUME = 2;
  localparam int CON_PPRST = 1;
  localparam int CON_EN = 0;
  localparam int ADDR_SLOW = 7;
  localparam int CFG1_MON = 6;
  localparam int CFG1_SIDL = 4;
  localparam int CFG2_XCVR_OFF = 0;
  // ----------------------------------------
  // token codes, reset values and response codes
  // ----------------------------------------
  localparam logic [3:0] PID_SETUP = 4'hd;
  localparam logic [3:0] PID_IN = 4'h9;
  localparam logic [3:0] PID_OUT = 4'h1;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 10000000;
  localparam int FRAME_US = 1000;
  localparam int FRAME_CYC = CLK_HZ / 1000000 * FRAME_US;
endpackage

//--- rtl/usbcs_frame_tick.sv
module usbcs_frame_tick #(
  parameter int FRAME_CYC = usbcs_pkg::FRAME_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic run,
  // frame start pulse
  output logic tick
);
  // ----------------------------------------
  // millisecond counter
  // ----------------------------------------
  localparam int CW = $clog2(FRAME_CYC);
  localparam logic [CW-1:0] LAST = CW'(FRAME_CYC - 1);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic tick_r;
  wire wrap = (cnt_r == LAST);

  // restart on enable so the first frame is a full one
  assign cnt_nxt = (!run || wrap) ? '0 : cnt_r + CW'(1);
  assign tick = tick_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= run && wrap;
    end
  end
endmodule // usbcs_frame_tick

//--- rtl/usbcs_regs.sv
module usbcs_regs #(
  parameter int FRAME_CYC = usbcs_pkg::FRAME_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // transfer engine events
  input wire logic xfer_done,
  input wire logic [3:0] xfer_ep,
  input wire logic xfer_tx,
  input wire logic xfer_odd,
  input wire logic setup_rx,
  input wire logic token_done,
  // line receiver and driver
  input wire logic line_dp,
  input wire logic line_dm,
  input wire logic line_driving,
  // system
  input wire logic cpu_idle,
  input wire logic dual_role_features_enable,
  input wire logic [2:0] otg_pulls,
  // bus control outputs
  output logic dp_pullup,
  output logic dp_pulldown,
  output logic dm_pulldown,
  output logic resume_drive,
  output logic bus_reset_drive,
  output logic frame_marker_send,
  output logic pingpong_pointer_clear,
  output logic packet_handling_halt,
  output logic module_active,
  output logic host_mode,
  output logic slow_rate_select,
  output logic [6:0] function_address,
  // token engine outputs
  output logic token_start,
  output logic [3:0] token_pid,
  output logic [3:0] token_target_endpoint,
  output logic token_in_progress,
  output logic [7:0] frame_threshold_value,
  // configuration outputs
  output logic [1:0] pingpong_config,
  output logic internal_transceiver_off,
  output logic line_drive_monitor
);
  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [7:0] stat_r;
  logic pkt_r, host_r, resume_r, pprst_r, attach_r, frame_en_r, reset_drv_r;
  logic busy_r, tokgo_r;
  logic [7:0] addr_r, tok_r, sof_r, cfg1_r, cfg2_r;
  logic aw_full_r, w_full_r, bvalid_r, rvalid_r;
  logic [7:0] wa_r;
  logic [7:0] wd_r;
  logic ws_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;

  // ----------------------------------------
  // live line flags
  // ----------------------------------------
  wire se0 = !line_dp && !line_dm;
  // j is differential one at full speed, zero at low speed
  wire jst = addr_r[usbcs_pkg::ADDR_SLOW] ?
    (!line_dp && line_dm) : (line_dp && !line_dm);

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  wire do_wr = aw_full_r && w_full_r && !bvalid_r;
  // upper byte lanes carry nothing, so only lane 0 matters
  wire wr_lo = do_wr && ws_r;
  wire wr_con = wr_lo && (wa_r == usbcs_pkg::OFF_CON);
  wire wr_addr = wr_lo && (wa_r == usbcs_pkg::OFF_ADDR);
  wire wr_tok = wr_lo && (wa_r == usbcs_pkg::OFF_TOK);
  wire wr_sof = wr_lo && (wa_r == usbcs_pkg::OFF_SOF);
  wire wr_cfg1 = wr_lo && (wa_r == usbcs_pkg::OFF_CFG1);
  wire wr_cfg2 = wr_lo && (wa_r == usbcs_pkg::OFF_CFG2);
  wire wa_ok = (wa_r[1:0] == 2'h0) && (wa_r <= usbcs_pkg::OFF_CFG2);
  wire ar_ok = (araddr[1:0] == 2'h0) && (araddr <= usbcs_pkg::OFF_CFG2);

  // ----------------------------------------
  // control next values
  // ----------------------------------------
  wire dev_mode = !host_r;
  wire [7:0] cw = wd_r;
  // setup in device mode wins over a clear in the same cycle
  wire pkt_set = setup_rx && dev_mode;
  wire pkt_nxt = pkt_set ? 1'b1 :
    ((wr_con && dev_mode) ? cw[usbcs_pkg::CON_PKT] : pkt_r);
  // bit 0 means module enable in device mode, frame enable in host mode
  wire attach_nxt = (wr_con && dev_mode) ?
    cw[usbcs_pkg::CON_EN] : attach_r;
  wire frame_en_nxt = (wr_con && host_r) ?
    cw[usbcs_pkg::CON_EN] : frame_en_r;
  wire reset_drv_nxt = (wr_con && host_r) ?
    cw[usbcs_pkg::CON_RST] : reset_drv_r;
  // token busy: done wins only if no new token written that cycle
  wire busy_nxt = wr_tok ? 1'b1 :
    (token_done ? 1'b0 : busy_r);

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  wire [7:0] con_dev = {1'b0, se0, pkt_r, 1'b0, host_r,
    resume_r, pprst_r, attach_r};
  wire [7:0] con_host = {jst, se0, busy_r, reset_drv_r, host_r,
    resume_r, pprst_r, frame_en_r};
  wire [7:0] addr_rd = {addr_r[7] && host_r, addr_r[6:0]};
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = usbcs_pkg::RST_BYTE;
    unique case (araddr)
      usbcs_pkg::OFF_STAT: rd_byte = stat_r;
      usbcs_pkg::OFF_CON: rd_byte = host_r ? con_host : con_dev;
      usbcs_pkg::OFF_ADDR: rd_byte = addr_rd;
      usbcs_pkg::OFF_TOK: rd_byte = tok_r;
      usbcs_pkg::OFF_SOF: rd_byte = sof_r;
      usbcs_pkg::OFF_CFG1: rd_byte = cfg1_r;
      usbcs_pkg::OFF_CFG2: rd_byte = cfg2_r;
      default: rd_byte = usbcs_pkg::RST_BYTE;
    endcase
  end

  // ----------------------------------------
  // axi4-lite handshakes
  // ----------------------------------------
  assign awready = !aw_full_r;
  assign wready = !w_full_r;
  assign arready = !rvalid_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = rdata_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      wa_r <= usbcs_pkg::RST_BYTE;
      wd_r <= usbcs_pkg::RST_BYTE;
      ws_r <= 1'b0;
    end else begin
      if (awvalid && !aw_full_r) begin
        aw_full_r <= 1'b1;
        wa_r <= awaddr;
      end else if (do_wr) begin
        aw_full_r <= 1'b0;
      end
      if (wvalid && !w_full_r) begin
        w_full_r <= 1'b1;
        wd_r <= wdata[7:0];
        ws_r <= wstrb[0];
      end else if (do_wr) begin
        w_full_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= usbcs_pkg::RESP_OKAY;
    end else if (do_wr) begin
      bvalid_r <= 1'b1;
      bresp_r <= wa_ok ? usbcs_pkg::RESP_OKAY : usbcs_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= usbcs_pkg::RESP_OKAY;
    end else if (arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r <= {24'h000000, rd_byte};
      rresp_r <= ar_ok ? usbcs_pkg::RESP_OKAY : usbcs_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // last transfer status
  // ----------------------------------------
  // status only moves on the engine's event; bus writes never reach it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_r <= usbcs_pkg::RST_BYTE;
    end else if (xfer_done) begin
      stat_r <= {xfer_ep, xfer_tx, xfer_odd, 2'h0};
    end
  end

  // ----------------------------------------
  // control register
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pkt_r <= 1'b0;
      host_r <= 1'b0;
      resume_r <= 1'b0;
      pprst_r <= 1'b0;
      attach_r <= 1'b0;
      frame_en_r <= 1'b0;
      reset_drv_r <= 1'b0;
      busy_r <= 1'b0;
      tokgo_r <= 1'b0;
    end else begin
      pkt_r <= pkt_nxt;
      attach_r <= attach_nxt;
      frame_en_r <= frame_en_nxt;
      reset_drv_r <= reset_drv_nxt;
      busy_r <= busy_nxt;
      tokgo_r <= wr_tok;
      if (wr_con) begin
        host_r <= cw[usbcs_pkg::CON_HOST];
        resume_r <= cw[usbcs_pkg::CON_RESUME];
        pprst_r <= cw[usbcs_pkg::CON_PPRST];
      end
    end
  end

  // ----------------------------------------
  // plain read/write registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_r <= usbcs_pkg::RST_BYTE;
      tok_r <= usbcs_pkg::RST_BYTE;
      sof_r <= usbcs_pkg::RST_BYTE;
      cfg1_r <= usbcs_pkg::RST_BYTE;
      cfg2_r <= usbcs_pkg::RST_BYTE;
    end else begin
      if (wr_addr) addr_r <= cw;
      if (wr_tok) tok_r <= cw;
      if (wr_sof) sof_r <= cw;
      if (wr_cfg1) cfg1_r <= cw & 8'hd3;
      if (wr_cfg2) cfg2_r <= cw & 8'h1f;
    end
  end

  // ----------------------------------------
  // frame marker timing
  // ----------------------------------------
  wire frame_run = host_r && frame_en_r && module_active;
  usbcs_frame_tick #(
    .FRAME_CYC(FRAME_CYC)
  ) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(frame_run),
    .tick(frame_marker_send)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  wire auto_pulls = !dual_role_features_enable;
  assign dp_pullup = auto_pulls ?
    (attach_r && dev_mode) : otg_pulls[2];
  assign dp_pulldown = auto_pulls ? host_r : otg_pulls[1];
  assign dm_pulldown = auto_pulls ? host_r : otg_pulls[0];
  assign resume_drive = resume_r;
  assign bus_reset_drive = host_r && reset_drv_r;
  assign pingpong_pointer_clear = pprst_r;
  assign packet_handling_halt = pkt_r && dev_mode;
  // idle stop only gates activity; register contents survive it
  assign module_active = (attach_r || host_r) &&
    !(cfg1_r[usbcs_pkg::CFG1_SIDL] && cpu_idle);
  assign host_mode = host_r;
  assign slow_rate_select = host_r && addr_r[usbcs_pkg::ADDR_SLOW];
  assign function_address = addr_r[6:0];
  assign token_start = tokgo_r;
  assign token_pid = tok_r[7:4];
  assign token_target_endpoint = tok_r[3:0];
  assign token_in_progress = busy_r;
  assign frame_threshold_value = sof_r;
  assign pingpong_config = cfg1_r[1:0];
  assign internal_transceiver_off = cfg2_r[usbcs_pkg::CFG2_XCVR_OFF];
  assign line_drive_monitor = cfg1_r[usbcs_pkg::CFG1_MON] &&
    cfg2_r[usbcs_pkg::CFG2_XCVR_OFF] && line_driving;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_STAT_ENDPOINT: assert property (xfer_done |=>
    stat_r[7:3] == {$past(xfer_ep), $past(xfer_tx)})
    else $error("status endpoint or direction wrong");
  AST_STAT_BANK: assert property (xfer_done |=>
    stat_r[2] == $past(xfer_odd) && stat_r[1:0] == 2'h0)
    else $error("status bank flag wrong");
  AST_SE0_READ: assert property (arvalid && arready &&
    araddr == usbcs_pkg::OFF_CON |=> rdata[6] == $past(se0))
    else $error("live se0 flag not read back");
  AST_SETUP_HALT: assert property (setup_rx && dev_mode |=>
    packet_handling_halt)
    else $error("setup did not halt packet handling");
  AST_HOST_PULLS: assert property (auto_pulls && host_r |->
    dp_pulldown && dm_pulldown && !dp_pullup)
    else $error("host pull-downs missing");
  AST_ATTACH_PULL: assert property (wr_con && dev_mode &&
    cw[0] && auto_pulls ##1 !host_r |-> dp_pullup)
    else $error("attach did not raise d+ pull-up");
  AST_TOK_BUSY: assert property (wr_tok |=>
    token_in_progress && token_start)
    else $error("token busy not raised");
  AST_RST_DRIVE: assert property (wr_con && host_r &&
    cw[usbcs_pkg::CON_HOST] |=>
    bus_reset_drive == $past(cw[usbcs_pkg::CON_RST]))
    else $error("bus reset not driven");
  AST_FRAME_GATE: assert property (frame_marker_send |->
    $past(host_r) && $past(frame_en_r))
    else $error("frame marker while disabled");
  AST_SLOW_DEV: assert property (arvalid && arready && !host_r &&
    araddr == usbcs_pkg::OFF_ADDR |=> !rdata[usbcs_pkg::ADDR_SLOW])
    else $error("slow rate reads set in device mode");
  AST_MON_GATE: assert property (!internal_transceiver_off |->
    !line_drive_monitor)
    else $error("monitor active with transceiver on");
  AST_UPPER_ZERO: assert property (rvalid |->
    rdata[31:8] == 24'h000000)
    else $error("upper bytes not zero");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped");

  COV_SETUP: cover property (setup_rx && dev_mode ##1 pkt_r);
  COV_FRAME: cover property (frame_marker_send);
  COV_TOKEN: cover property (wr_tok ##[1:20] token_done);
  COV_WRITE: cover property (bvalid && bready);
endmodule // usbcs_regs

//--- testbench/usbcs_far_model.sv
module usbcs_far_model (
  // clock
  input wire logic aclk,
  // token handshake
  input wire logic token_start,
  output logic token_done,
  // transfer events
  output logic xfer_done,
  output logic [3:0] xfer_ep,
  output logic xfer_tx,
  output logic xfer_odd,
  output logic setup_rx,
  // line levels
  output logic line_dp,
  output logic line_dm,
  output logic line_driving
);
  timeunit 1ns;
  timeprecision 1ns;
  int tok_delay = 1;
  int tok_cnt = 0;
  // ----------------------------------------
  // idle state: full-speed j on the lines
  // ----------------------------------------
  initial begin
    {token_done, xfer_done, xfer_ep, xfer_tx, xfer_odd} = '0;
    {setup_rx, line_dp, line_dm, line_driving} = 4'b0100;
  end
  // token ends tok_delay cycles after it starts, prompt or slow
  always @(posedge aclk) begin
    token_done <= (tok_cnt == 1) && !token_start;
    if (token_start)
      tok_cnt <= tok_delay;
    else if (tok_cnt > 0)
      tok_cnt <= tok_cnt - 1;
  end
  task automatic xfer(input logic [3:0] ep, input logic tx, input logic o);
    @(posedge aclk);
    xfer_done <= 1'b1;
    xfer_ep <= ep;
    xfer_tx <= tx;
    xfer_odd <= o;
    @(posedge aclk);
    xfer_done <= 1'b0;
    // stale fields are scrambled so nothing leans on them
    xfer_ep <= ~ep;
    xfer_tx <= ~tx;
    xfer_odd <= ~o;
  endtask
  task automatic setup_tok;
    @(posedge aclk);
    setup_rx <= 1'b1;
    @(posedge aclk);
    setup_rx <= 1'b0;
  endtask
  task automatic lines(input logic dp, input logic dm);
    @(posedge aclk);
    line_dp <= dp;
    line_dm <= dm;
    repeat (3) @(posedge aclk);
  endtask
endmodule // usbcs_far_model

//--- testbench/tb_usb_otg_control_status_regs.sv
module tb_usb_otg_control_status_regs;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int FC = 20;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, cpu_idle;
  logic [7:0] awaddr, araddr, frame_threshold_value;
  logic [31:0] wdata, rdata, rd_v;
  logic [3:0] wstrb, xfer_ep, token_pid, token_target_endpoint;
  logic [1:0] bresp, rresp, rsp, exp_rsp, pingpong_config;
  logic xfer_done, xfer_tx, xfer_odd, setup_rx, token_done, token_start;
  logic line_dp, line_dm, line_driving, dp_pullup, dp_pulldown, dm_pulldown;
  logic resume_drive, bus_reset_drive, frame_marker_send, module_active;
  logic pingpong_pointer_clear, packet_handling_halt, host_mode;
  logic slow_rate_select, token_in_progress, internal_transceiver_off;
  logic line_drive_monitor, dual_role;
  logic [2:0] otg_pulls;
  logic [6:0] function_address;
  logic [3:0] pids [3];
  int dly [3] = '{30, 30, 1};
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;
  usbcs_regs #(.FRAME_CYC(FC)) DUT (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0),
    .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
    .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata,
    .rresp, .xfer_done, .xfer_ep, .xfer_tx, .xfer_odd, .setup_rx,
    .token_done, .line_dp, .line_dm, .line_driving, .cpu_idle,
    .dual_role_features_enable(dual_role), .otg_pulls, .dp_pullup,
    .dp_pulldown, .dm_pulldown, .resume_drive, .bus_reset_drive,
    .frame_marker_send, .pingpong_pointer_clear, .packet_handling_halt,
    .module_active, .host_mode, .slow_rate_select, .function_address,
    .token_start, .token_pid, .token_target_endpoint, .token_in_progress,
    .frame_threshold_value, .pingpong_config, .internal_transceiver_off,
    .line_drive_monitor
  );
  usbcs_far_model far (
    .aclk, .token_start, .token_done, .xfer_done, .xfer_ep, .xfer_tx,
    .xfer_odd, .setup_rx, .line_dp, .line_dm, .line_driving
  );
  // ----------------------------------------
  // clock, watchdog and verdict
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task automatic print_verdict;
    if (num_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // whole run needs a few hundred cycles; a hang is stopped at 20000
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      print_verdict();
    end
  end
  // ----------------------------------------
  // axi4-lite master tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      num_errors++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
    check("bresp", 32'(exp_rsp), 32'(rsp));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd_v = rdata;
    rsp = rresp;
    rready <= 1'b0;
    check("rresp", 32'(exp_rsp), 32'(rsp));
    check($sformatf("reg %h", a), e, rd_v);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    pids = '{usbcs_pkg::PID_SETUP, usbcs_pkg::PID_IN, usbcs_pkg::PID_OUT};
    {aresetn, awvalid, wvalid, bready, arvalid, rready, cpu_idle} = '0;
    dual_role = 1'b0;
    otg_pulls = 3'h5;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    exp_rsp = usbcs_pkg::RESP_OKAY;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 7; i++) rd(8'(4 * i), 32'h0);
    exp_rsp = usbcs_pkg::RESP_SLVERR;
    rd(8'h1c, 32'h0);
    wr(8'h1c, 32'hff);
    exp_rsp = usbcs_pkg::RESP_OKAY;
    wr(8'h08, 32'hffffffff);
    rd(8'h08, 32'h7f);
    check("address", 32'h7f, 32'(function_address));
    far.xfer(4'hf, 1'b1, 1'b1);
    rd(8'h00, 32'hfc);
    wr(8'h00, 32'hff);
    rd(8'h00, 32'hfc);
    far.xfer(4'h0, 1'b0, 1'b0);
    rd(8'h00, 32'h00);
    far.lines(1'b0, 1'b0);
    rd(8'h04, 32'h40);
    far.lines(1'b1, 1'b0);
    wr(8'h04, 32'h07);
    rd(8'h04, 32'h07);
    check("ctl outs", 32'hf, 32'({dp_pullup,
      resume_drive, pingpong_pointer_clear, module_active}));
    far.setup_tok();
    rd(8'h04, 32'h27);
    check("halt", 32'h1, 32'(packet_handling_halt));
    wr(8'h04, 32'h01);
    check("halt clr", 32'h0, 32'(packet_handling_halt));
    wr(8'h14, 32'hff);
    rd(8'h14, 32'hd3);
    check("ppcfg", 32'h3, 32'(pingpong_config));
    wr(8'h14, 32'h51);
    check("ppcfg", 32'h1, 32'(pingpong_config));
    @(posedge aclk) cpu_idle <= 1'b1;
    @(posedge aclk);
    check("idle halt", 32'h0, 32'(module_active));
    cpu_idle <= 1'b0;
    wr(8'h18, 32'hff);
    rd(8'h18, 32'h1f);
    far.line_driving <= 1'b1;
    @(posedge aclk);
    check("monitor", 32'h3, 32'({internal_transceiver_off,
      line_drive_monitor}));
    wr(8'h18, 32'h00);
    check("monitor", 32'h0, 32'(line_drive_monitor));
    far.line_driving <= 1'b0;
    wr(8'h04, 32'h00);
    check("detach", 32'h0, 32'({dp_pullup, module_active}));
    // back to full speed so the host j flag follows d+ high
    wr(8'h08, 32'h05);
    wr(8'h04, 32'h08);
    far.setup_tok();
    rd(8'h04, 32'h88);
    check("host outs", 32'hf, 32'({host_mode, dp_pulldown,
      dm_pulldown, !packet_handling_halt}));
    @(posedge aclk) dual_role <= 1'b1;
    @(posedge aclk);
    check("otg pulls", 32'h5, 32'({dp_pullup,
      dp_pulldown, dm_pulldown}));
    dual_role <= 1'b0;
    wr(8'h04, 32'h19);
    rd(8'h04, 32'h99);
    check("bus reset", 32'h1, 32'(bus_reset_drive));
    repeat (2) begin
      n = 0;
      do begin
        @(posedge aclk);
        n++;
      end while (frame_marker_send !== 1'b1 && n < 100);
    end
    check("frame gap", 32'(FC), 32'(n));
    wr(8'h04, 32'h08);
    check("bus reset", 32'h0, 32'(bus_reset_drive));
    wr(8'h08, 32'h85);
    rd(8'h08, 32'h85);
    check("slow", 32'h1, 32'(slow_rate_select));
    rd(8'h04, 32'h08);
    far.lines(1'b0, 1'b1);
    rd(8'h04, 32'h88);
    far.lines(1'b1, 1'b0);
    wr(8'h08, 32'h05);
    for (int i = 0; i < 3; i++) begin
      far.tok_delay = dly[i];
      wr(8'h0c, {24'h0, pids[i], 4'(i + 2)});
      if (dly[i] > 5) rd(8'h04, 32'ha8);
      check("token", {24'h0, pids[i], 4'(i + 2)},
        {24'h0, token_pid, token_target_endpoint});
      repeat (40) @(posedge aclk);
      rd(8'h04, 32'h88);
      check("tok busy", 32'h0, 32'(token_in_progress));
    end
    wr(8'h10, 32'h4a);
    rd(8'h10, 32'h4a);
    check("threshold", 32'h4a, 32'(frame_threshold_value));
    print_verdict();
  end
endmodule // tb_usb_otg_control_status_regs
